/* rtl/bcc_pkg.sv */
// bcc_pkg: shared constants, types and helpers of the bcd clock/calendar core
package bcc_pkg;

	// ====================================================================
	// clocking and timing
	localparam int unsigned CLK_HZ        = 10_000_000;  // core clock, 100 ns
	localparam int unsigned OSC_HZ        = 32_768;      // crystal rate
	localparam int unsigned DEFER_MS      = 250;         // longest display hold-off
	// longest time: integer division rounds down
	localparam int unsigned DEFER_CYCLES  = (CLK_HZ / 1000) * DEFER_MS;
	localparam int unsigned DEFER_W       = 22;

	// ====================================================================
	// register offsets (byte pointer positions)
	localparam logic [2:0] ADDR_SECONDS   = 3'h0;
	localparam logic [2:0] ADDR_MINUTES   = 3'h1;
	localparam logic [2:0] ADDR_HOURS     = 3'h2;
	localparam logic [2:0] ADDR_WEEKDAY   = 3'h3;
	localparam logic [2:0] ADDR_MONTH_DAY = 3'h4;
	localparam logic [2:0] ADDR_MONTH     = 3'h5;
	localparam logic [2:0] ADDR_YEAR      = 3'h6;
	localparam logic [2:0] ADDR_CTRL      = 3'h7;
	localparam int unsigned TIME_REGS     = 7;

	// ====================================================================
	// field positions
	localparam int unsigned OSC_HALT_BIT   = 7;  // seconds register
	localparam int unsigned CENTURY_FLAG_BIT = 7;  // hours register
	localparam int unsigned CENTURY_EN_BIT = 6;  // hours register
	localparam int unsigned WDAY_MSB       = 2;  // weekday count in bits 2..0
	localparam int unsigned TEST_TAP       = 5;  // 32768 / 2^6 = 512 Hz

	// ====================================================================
	// reset values and counter limits
	localparam logic [7:0] CTRL_RESET     = 8'h80;  // level bit set, test off
	localparam logic [7:0] TIME_RESET     = 8'h00;
	localparam logic [7:0] DATE_RESET     = 8'h01;
	localparam logic [6:0] SEC_MAX        = 7'h59;
	localparam logic [6:0] MIN_MAX        = 7'h59;
	localparam logic [5:0] HOUR_MAX       = 6'h23;
	localparam logic [2:0] WDAY_MAX       = 3'h7;
	localparam logic [7:0] MONTH_MAX      = 8'h12;
	localparam logic [7:0] YEAR_MAX       = 8'h99;

	// ====================================================================
	// calibration: seconds measured in oscillator cycles
	localparam logic [16:0] SEC_LEN       = 17'h08000;  // 32768 cycles
	localparam logic [16:0] CAL_SHORTEN   = 17'h00080;  // 128 cycles blanked
	localparam logic [16:0] CAL_LENGTHEN  = 17'h00100;  // 256 cycles added
	localparam logic [5:0]  CAL_LAST_MIN  = 6'h3E;      // minute 62 of 64

	// ====================================================================
	// types
	typedef struct packed {
		logic       out_level;     // bit 7
		logic       freq_test_select; // bit 6
		logic       cal_positive;  // bit 5
		logic [4:0] cal_mag;       // bits 4..0
	} bcc_ctrl_t;

	typedef struct packed {
		logic alter;     // this second is the corrected one
		logic positive;  // lengthen rather than shorten
	} bcc_cal_t;

	// ====================================================================
	// helpers
	function automatic logic [7:0] bcc_bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcc_bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcc_bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcc_bcd_inc

	// last day of a month, leap years every fourth bcd year
	function automatic logic [7:0] bcc_month_last(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8))
			|| (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
		case (mon)
			8'h02:   bcc_month_last = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: bcc_month_last = 8'h30;
			default: bcc_month_last = 8'h31;
		endcase
	endfunction : bcc_month_last

endpackage : bcc_pkg

/* rtl/bcc_osc_div.sv */
// bcc_osc_div: crystal sampler, calibrated seconds divider and test tap
`timescale 1ns/1ps
`default_nettype none
module bcc_osc_div
	import bcc_pkg::*;
(
	// clock and reset
	input  wire logic     i_clk,
	input  wire logic     i_rst_b,
	// oscillator and control
	input  wire logic     i_osc,
	input  wire logic     i_halt,
	input  wire bcc_cal_t i_cal,
	// outputs
	output logic          o_sec_tick,
	output logic          o_test_wave
);

	// ====================================================================
	// crystal input synchroniser
	logic        osc_s1_q, osc_s2_q, osc_s3_q;
	logic        osc_edge;
	logic [16:0] cnt_q, cnt_d, sec_limit;
	logic [5:0]  tap_q, tap_d;
	logic        tick_q, tick_d;

	// two flops before use; third only remembers the last level
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end else begin
			osc_s1_q <= i_osc;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	// a halted oscillator produces no edges at all
	assign osc_edge = osc_s2_q && !osc_s3_q && !i_halt; // [R5]

	// ====================================================================
	// dividers: test tap runs before the correction point
	always_comb begin
		sec_limit = SEC_LEN;
		if (i_cal.alter) begin
			sec_limit = i_cal.positive ? SEC_LEN + CAL_LENGTHEN  // [R11]
				: SEC_LEN - CAL_SHORTEN; // [R8] [R11]
		end
		cnt_d  = cnt_q;
		tap_d  = tap_q;
		tick_d = 1'b0;
		if (osc_edge) begin
			tap_d = tap_q + 6'h01; // [R14]
			if (cnt_q >= sec_limit - 17'h00001) begin
				cnt_d  = 17'h00000;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 17'h00001;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q  <= 17'h00000;
			tap_q  <= 6'h00;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tap_q  <= tap_d;
			tick_q <= tick_d;
		end
	end

	assign o_sec_tick  = tick_q;
	assign o_test_wave = tap_q[TEST_TAP]; // [R13]

	// ====================================================================
	// checks
	a_halt_no_tick : assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R5]
		i_halt |=> !tick_q)
		else $error("second tick while oscillator halted");

	a_len_bound : assert property (@(posedge i_clk) disable iff (!i_rst_b) // [R11]
		cnt_q <= SEC_LEN + CAL_LENGTHEN)
		else $error("seconds divider ran past longest second");

endmodule : bcc_osc_div
`default_nettype wire

/* rtl/bcc_clock_core.sv */
// bcc_clock_core: bcd clock/calendar registers, display hold-off, pin drive
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - seven bcd time registers at 0..6, control at 7, all readable and writable
// R2 - hours register carries century enable in bit 6, century flag in bit 7
// R3 - century flag inverts at year rollover only while century enable is set
// R4 - weekday in bits 2..0 of register 3; registers 4..6 date, month, year
// R5 - seconds bit 7 halts oscillator; clearing it resumes counting within a second
// R6 - time registers read singly or in bursts; control register accessed alone; here a burst read or write steps from 6 on into it
// R7 - display update held off up to 250 ms during reads; live count continues
// R8 - correction acts on divider chain; positive adds counts, negative blanks
// R9 - calibration magnitude 0..31 in control bits 4..0
// R10 - control bit 5 selects direction: one positive, zero negative
// R11 - 64-minute cycle; altered second shortened 128 or lengthened 256 cycles
// R12 - magnitude N corrects the first 2N minutes, never past minute 62
// R13 - test bit set makes the pin toggle at 512 Hz from the divider
// R14 - test frequency tap sits ahead of calibration and never changes with it
// R15 - test bit clear: pin low when level bit zero, released when one
// R16 - pin is open drain, only pulls low, high comes from pull-up
// R17 - after power-up test bit is zero and level bit is one
// R18 - read pointer advances only when the host acknowledges a byte
// R19 - bcd counters roll at natural limits and carry, month length applied
module bcc_clock_core
	import bcc_pkg::*;
#(
	parameter int unsigned DEFER_LIMIT = DEFER_CYCLES
)(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// crystal oscillator pin
	input  wire logic       i_osc,
	// byte port from the serial bus slave
	input  wire logic       i_ptr_load,
	input  wire logic [2:0] i_ptr_addr,
	input  wire logic       i_wr_stb,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_rd_stb,
	input  wire logic       i_rd_ack,
	input  wire logic       i_rd_busy,
	output logic [7:0]      o_rd_data,
	output logic [2:0]      o_ptr,
	// test or level pin, open drain
	input  wire logic       i_pin_in,
	output logic            o_pin_out,
	output logic            o_pin_oe
);

	// ====================================================================
	// state
	logic [7:0]      live_q [TIME_REGS];
	logic [7:0]      live_d [TIME_REGS];
	logic [7:0]      shad_q [TIME_REGS];
	logic [7:0]      shad_d [TIME_REGS];
	bcc_ctrl_t       ctrl_q, ctrl_d;
	logic [2:0]      ptr_q, ptr_d;
	logic [7:0]      rd_q, rd_d;
	logic            pend_q, pend_d;
	logic [DEFER_W-1:0] defer_q, defer_d;
	logic [5:0]      mcyc_q, mcyc_d;
	logic            pin_oe_q, pin_oe_d;
	logic            sec_tick, test_wave, reading, transfer, min_wrap, wr_time;
	bcc_cal_t        cal;
	logic [7:0]      sec_v, min_v, hr_v, wd_v, date_v, mon_v, yr_v;

	// ====================================================================
	// seconds divider with calibration
	// eligible minute: index below twice the magnitude, max 62 by width
	assign cal.alter    = (mcyc_q < {ctrl_q.cal_mag, 1'b0}) // [R12]
		&& (live_q[ADDR_SECONDS][6:0] == 7'h00);
	assign cal.positive = ctrl_q.cal_positive; // [R8] [R10]

	bcc_osc_div u_div (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_osc       (i_osc),
		.i_halt      (live_q[ADDR_SECONDS][OSC_HALT_BIT]), // [R5]
		.i_cal       (cal),
		.o_sec_tick  (sec_tick),
		.o_test_wave (test_wave) // [R14]
	);

	// ====================================================================
	// live time counters
	assign wr_time  = i_wr_stb && (ptr_q != ADDR_CTRL);
	// minute boundary; steps the 64-minute correction cycle
	assign min_wrap = sec_tick && (live_q[ADDR_SECONDS][6:0] == SEC_MAX);

	// carry chain; a byte written in the same cycle overrides its count
	always_comb begin
		sec_v  = live_q[ADDR_SECONDS];
		min_v  = live_q[ADDR_MINUTES];
		hr_v   = live_q[ADDR_HOURS];
		wd_v   = live_q[ADDR_WEEKDAY];
		date_v = live_q[ADDR_MONTH_DAY];
		mon_v  = live_q[ADDR_MONTH];
		yr_v   = live_q[ADDR_YEAR];
		if (sec_tick) begin
			if (sec_v[6:0] != SEC_MAX) begin
				sec_v = bcc_bcd_inc(sec_v); // [R19]
			end else begin
				sec_v[6:0] = 7'h00;
				if (min_v[6:0] != MIN_MAX) begin
					min_v = bcc_bcd_inc(min_v);
				end else begin
					min_v[6:0] = 7'h00;
					if (hr_v[5:0] != HOUR_MAX) begin
						hr_v[5:0] = 6'(bcc_bcd_inc({2'b00, hr_v[5:0]}));
					end else begin
						hr_v[5:0] = 6'h00;
						// weekday wraps 7 to 1
						wd_v[WDAY_MSB:0] = (wd_v[WDAY_MSB:0] == WDAY_MAX) // [R4]
							? 3'h1 : wd_v[WDAY_MSB:0] + 3'h1;
						if (date_v != bcc_month_last(mon_v, yr_v)) begin
							date_v = bcc_bcd_inc(date_v); // [R19]
						end else begin
							date_v = DATE_RESET;
							if (mon_v != MONTH_MAX) begin
								mon_v = bcc_bcd_inc(mon_v);
							end else begin
								mon_v = DATE_RESET;
								if (yr_v != YEAR_MAX) begin
									yr_v = bcc_bcd_inc(yr_v);
								end else begin
									yr_v = TIME_RESET;
									if (hr_v[CENTURY_EN_BIT]) begin
										hr_v[CENTURY_FLAG_BIT] = ~hr_v[CENTURY_FLAG_BIT]; // [R3]
									end
								end
							end
						end
					end
				end
			end
		end
		live_d[ADDR_SECONDS]   = sec_v;
		live_d[ADDR_MINUTES]   = min_v;
		live_d[ADDR_HOURS]     = hr_v; // [R2]
		live_d[ADDR_WEEKDAY]   = wd_v;
		live_d[ADDR_MONTH_DAY] = date_v;
		live_d[ADDR_MONTH]     = mon_v;
		live_d[ADDR_YEAR]      = yr_v;
		if (wr_time) begin
			live_d[ptr_q] = i_wr_data; // [R1]
		end
	end

	// ====================================================================
	// readable copy and its hold-off
	// a byte read mid-carry could mix old and new fields, hence the copy
	assign reading  = i_rd_busy && (ptr_q != ADDR_CTRL); // [R7]
	assign transfer = pend_q && (!reading
		|| defer_q >= DEFER_W'(DEFER_LIMIT - 1)); // [R7]

	always_comb begin
		shad_d  = shad_q;
		pend_d  = pend_q;
		defer_d = defer_q;
		if (transfer) begin
			shad_d  = live_q;
			pend_d  = 1'b0;
			defer_d = '0;
		end else if (pend_q) begin
			defer_d = defer_q + 1'b1;
		end
		// a fresh tick wins over the clear of the same cycle
		if (sec_tick) begin
			pend_d = 1'b1;
		end
		if (wr_time) begin
			shad_d[ptr_q] = i_wr_data;
		end
	end

	// ====================================================================
	// control register, pointer and read data
	always_comb begin
		ctrl_d = ctrl_q;
		ptr_d  = ptr_q;
		rd_d   = rd_q;
		if (i_wr_stb && ptr_q == ADDR_CTRL) begin
			ctrl_d = bcc_ctrl_t'(i_wr_data); // [R9] [R10]
		end
		if (i_rd_stb) begin
			// control byte is served directly, never through the copy
			rd_d = (ptr_q == ADDR_CTRL) ? ctrl_q : shad_q[ptr_q]; // [R6]
		end
		if (i_ptr_load) begin
			ptr_d = i_ptr_addr;
		end else if (i_wr_stb || i_rd_ack) begin
			ptr_d = ptr_q + 3'h1; // [R18]
		end
	end

	// ====================================================================
	// calibration minute cycle and pin drive
	always_comb begin
		mcyc_d = min_wrap ? mcyc_q + 6'h01 : mcyc_q; // [R11]
		// oe high pulls the pin low; the pull-up makes the high
		pin_oe_d = ctrl_q.freq_test_select ? !test_wave // [R13] [R16]
			: !ctrl_q.out_level; // [R15]
	end

	// ====================================================================
	// registers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < TIME_REGS; i++) begin
				live_q[i] <= (i == 4 || i == 5) ? DATE_RESET : TIME_RESET;
				shad_q[i] <= (i == 4 || i == 5) ? DATE_RESET : TIME_RESET;
			end
			ctrl_q   <= bcc_ctrl_t'(CTRL_RESET); // [R17]
			ptr_q    <= 3'h0;
			rd_q     <= 8'h00;
			pend_q   <= 1'b0;
			defer_q  <= '0;
			mcyc_q   <= 6'h00;
			pin_oe_q <= 1'b0;
		end else begin
			live_q   <= live_d;
			shad_q   <= shad_d;
			ctrl_q   <= ctrl_d;
			ptr_q    <= ptr_d;
			rd_q     <= rd_d;
			pend_q   <= pend_d;
			defer_q  <= defer_d;
			mcyc_q   <= mcyc_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	assign o_rd_data = rd_q;
	assign o_ptr     = ptr_q;
	assign o_pin_out = 1'b0; // [R16]
	assign o_pin_oe  = pin_oe_q;

	// ====================================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_year_wrap;
		sec_tick && min_wrap && live_q[ADDR_HOURS][5:0] == HOUR_MAX
			&& live_q[ADDR_MINUTES][6:0] == MIN_MAX
			&& live_q[ADDR_MONTH] == MONTH_MAX && live_q[ADDR_YEAR] == YEAR_MAX
			&& live_q[ADDR_MONTH_DAY] == 8'h31 && !wr_time;
	endsequence

	sequence s_flag_flipped;
		live_q[ADDR_HOURS][CENTURY_FLAG_BIT] != $past(live_q[ADDR_HOURS][CENTURY_FLAG_BIT])
			&& live_q[ADDR_YEAR] == 8'h00;
	endsequence

	a_century_flip : assert property ( // [R3]
		s_year_wrap and live_q[ADDR_HOURS][CENTURY_EN_BIT] |=> s_flag_flipped)
		else $error("century flag did not invert at year rollover");

	a_century_hold : assert property ( // [R3]
		!live_q[ADDR_HOURS][CENTURY_EN_BIT] && !wr_time
			|=> $stable(live_q[ADDR_HOURS][CENTURY_FLAG_BIT]))
		else $error("century flag changed while disabled");

	a_sec_wrap : assert property ( // [R19]
		sec_tick && live_q[ADDR_SECONDS][6:0] == SEC_MAX && !wr_time
			|=> live_q[ADDR_SECONDS][6:0] == 7'h00
			&& live_q[ADDR_MINUTES] != $past(live_q[ADDR_MINUTES]))
		else $error("seconds did not roll into minutes");

	a_ptr_ack_step : assert property ( // [R18]
		!i_ptr_load && !i_wr_stb |-> ##1 (ptr_q == $past(ptr_q) + ($past(i_rd_ack) ? 3'h1 : 3'h0)))
		else $error("pointer moved without acknowledge");

	a_defer_bound : assert property ( // [R7]
		defer_q < DEFER_W'(DEFER_LIMIT))
		else $error("display hold-off exceeded its limit");

	a_idle_transfer : assert property ( // [R7]
		pend_q && !reading |=> shad_q[ADDR_MINUTES] == $past(live_q[ADDR_MINUTES])
			|| $past(wr_time))
		else $error("copy not refreshed while no read active");

	a_cal_window : assert property ( // [R12]
		cal.alter |-> mcyc_q < CAL_LAST_MIN && mcyc_q < {ctrl_q.cal_mag, 1'b0})
		else $error("correction outside eligible minutes");

	a_pin_level : assert property ( // [R15]
		!ctrl_q.freq_test_select ##1 !$past(ctrl_q.freq_test_select)
			|-> o_pin_oe == !$past(ctrl_q.out_level))
		else $error("pin does not follow level bit");

	a_pin_test : assert property ( // [R13]
		ctrl_q.freq_test_select && $past(ctrl_q.freq_test_select) && $changed(test_wave)
			|=> $changed(o_pin_oe))
		else $error("pin does not follow test wave");

	// copy must stay frozen while a time read is open and the limit is not reached
	a_copy_held : assert property ( // [R7]
		pend_q && reading && defer_q < DEFER_W'(DEFER_LIMIT - 1) && !wr_time
			|=> $stable(shad_q[ADDR_SECONDS]))
		else $error("copy refreshed during an open time read");

	a_ctrl_write : assert property ( // [R9]
		i_wr_stb && ptr_q == ADDR_CTRL |=> ctrl_q == $past(i_wr_data))
		else $error("control byte not taken from the write");

	a_wday_wrap : assert property ( // [R4]
		min_wrap && live_q[ADDR_MINUTES][6:0] == MIN_MAX
			&& live_q[ADDR_HOURS][5:0] == HOUR_MAX
			&& live_q[ADDR_WEEKDAY][WDAY_MSB:0] == WDAY_MAX && !wr_time
			|=> live_q[ADDR_WEEKDAY][WDAY_MSB:0] == 3'h1)
		else $error("weekday did not wrap to one");

endmodule : bcc_clock_core
`default_nettype wire

/* test/bcc_host_model.sv */
// bcc_host_model: byte-level host driving the core's register port
`timescale 1ns/1ps
`default_nettype none
module bcc_host_model (
	// clock
	input  wire logic       i_clk,
	// byte port toward the core
	output logic            o_ptr_load,
	output logic [2:0]      o_ptr_addr,
	output logic            o_wr_stb,
	output logic [7:0]      o_wr_data,
	output logic            o_rd_stb,
	output logic            o_rd_ack,
	output logic            o_rd_busy,
	input  wire logic [7:0] i_rd_data
);
	// ====================================================================
	// idle levels; released buses show inverted junk, never the last value
	initial begin
		o_ptr_load = 1'b0;
		o_ptr_addr = 3'h5;
		o_wr_stb   = 1'b0;
		o_wr_data  = 8'hA5;
		o_rd_stb   = 1'b0;
		o_rd_ack   = 1'b0;
		o_rd_busy  = 1'b0;
	end

	// ====================================================================
	// pointer load, one-cycle pulse
	task automatic set_ptr(input logic [2:0] a);
		@(negedge i_clk);
		o_ptr_load = 1'b1;
		o_ptr_addr = a;
		@(negedge i_clk);
		o_ptr_load = 1'b0;
		o_ptr_addr = ~a;
	endtask : set_ptr

	// byte write; core advances the pointer itself
	task automatic wr(input logic [7:0] d);
		@(negedge i_clk);
		o_wr_stb  = 1'b1;
		o_wr_data = d;
		@(negedge i_clk);
		o_wr_stb  = 1'b0;
		o_wr_data = ~d;
	endtask : wr

	// byte read inside an open transaction, ack optional
	task automatic rd(input logic ack, output logic [7:0] d);
		@(negedge i_clk);
		o_rd_busy = 1'b1;
		o_rd_stb  = 1'b1;
		@(negedge i_clk);
		o_rd_stb = 1'b0;
		d        = i_rd_data;
		if (ack) begin
			o_rd_ack = 1'b1; // only an ack moves the pointer
			@(negedge i_clk);
			o_rd_ack = 1'b0;
		end
	endtask : rd

	// close the read transaction; single or burst reads both allowed
	task automatic rd_end();
		@(negedge i_clk);
		o_rd_busy = 1'b0;
	endtask : rd_end
endmodule : bcc_host_model
`default_nettype wire

/* test/tb.sv */
// tb: self-checking bench of the bcd clock/calendar core
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bcc_pkg::*;

	// ====================================================================
	// signals
	logic       clk;
	logic       rst_b;
	logic       osc;
	logic       ptr_load;
	logic [2:0] ptr_addr;
	logic       wr_stb;
	logic [7:0] wr_data;
	logic       rd_stb;
	logic       rd_ack;
	logic       rd_busy;
	logic [7:0] rd_data;
	logic [2:0] ptr;
	logic       pin_out;
	logic       pin_oe;
	wire  logic pin_wire;
	int         fail_count;
	int         n_tests;
	int         cyc;
	logic [7:0] d;
	int         tg;
	int         osc_half;

	// open drain pin with external pull-up
	assign pin_wire = pin_oe ? pin_out : 1'b1;

	// ====================================================================
	// clock, crystal at 400 ns period offset from the core clock; halved for rollover
	initial clk = 1'b0;
	always #50 clk = ~clk;
	initial begin
		osc      = 1'b0;
		osc_half = 200;
		#37;
		forever #(osc_half) osc = ~osc;
	end

	bcc_clock_core #(.DEFER_LIMIT(20)) DUT (
		.i_clk      (clk),
		.i_rst_b    (rst_b),
		.i_osc      (osc),
		.i_ptr_load (ptr_load),
		.i_ptr_addr (ptr_addr),
		.i_wr_stb   (wr_stb),
		.i_wr_data  (wr_data),
		.i_rd_stb   (rd_stb),
		.i_rd_ack   (rd_ack),
		.i_rd_busy  (rd_busy),
		.o_rd_data  (rd_data),
		.o_ptr      (ptr),
		.i_pin_in   (pin_wire),
		.o_pin_out  (pin_out),
		.o_pin_oe   (pin_oe)
	);

	bcc_host_model host (
		.i_clk      (clk),
		.o_ptr_load (ptr_load),
		.o_ptr_addr (ptr_addr),
		.o_wr_stb   (wr_stb),
		.o_wr_data  (wr_data),
		.o_rd_stb   (rd_stb),
		.o_rd_ack   (rd_ack),
		.o_rd_busy  (rd_busy),
		.i_rd_data  (rd_data)
	);

	// ====================================================================
	// reporting
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	// hang guard: the wait for the first tick dominates, about 72k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			final_report();
		end
	end

	// pin transitions over n cycles; 512 Hz here is one toggle per 128 cycles
	task automatic count_toggles(input int n, output int c);
		logic prev;
		c = 0;
		@(negedge clk);
		prev = pin_oe;
		repeat (n) begin
			@(negedge clk);
			if (pin_oe !== prev) c++;
			prev = pin_oe;
		end
	endtask : count_toggles

	// write one control byte and let the registered pin settle
	task automatic wr_ctrl(input logic [7:0] v);
		host.set_ptr(ADDR_CTRL);
		host.wr(v);
		repeat (3) @(negedge clk);
	endtask : wr_ctrl

	// ====================================================================
	// main sequence
	logic [7:0] exp_rst[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, CTRL_RESET};
	logic [7:0] pat[8]     = '{8'h45, 8'h59, 8'hC3, 8'h05, 8'h28, 8'h02, 8'h99, 8'h25};
	logic [7:0] roll_set[7] = '{8'h59, 8'h59, 8'h63, 8'h07, 8'h31, 8'h12, 8'h99};
	logic [7:0] roll_exp[7] = '{8'h00, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h00};

	initial begin
		fail_count = 0;
		n_tests    = 0;
		cyc        = 0;
		rst_b      = 1'b0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;

		// power-up values, burst read across all eight bytes
		check("pin_oe_reset", {7'h0, pin_oe}, 8'h00);
		host.set_ptr(ADDR_SECONDS);
		for (int i = 0; i < 8; i++) begin
			host.rd(1'b1, d);
			check("reset_byte", d, exp_rst[i]);
		end
		host.rd_end();
		$display("test reset_values done");

		// burst write of every byte, pointer wraps, read back
		host.set_ptr(ADDR_SECONDS);
		for (int i = 0; i < 8; i++) host.wr(pat[i]);
		repeat (2) @(negedge clk);
		check("ptr_wrap", {5'h0, ptr}, 8'h00);
		for (int i = 0; i < 8; i++) begin
			host.rd(1'b1, d);
			check("readback", d, pat[i]);
		end
		host.rd_end();
		check("pin_low_level0", {7'h0, pin_oe}, 8'h01);
		check("pin_out_low", {7'h0, pin_out}, 8'h00);
		$display("test write_readback done");

		// single reads of hours and weekday, no ack keeps the pointer
		host.set_ptr(ADDR_HOURS);
		host.rd(1'b0, d);
		check("hours_century", d, 8'hC3);
		host.rd(1'b0, d);
		check("ptr_no_ack", {5'h0, ptr}, {5'h0, ADDR_HOURS});
		host.rd(1'b1, d);
		host.rd(1'b1, d);
		check("weekday", d, 8'h05);
		host.rd_end();
		check("ptr_ack", {5'h0, ptr}, 8'h04);
		$display("test pointer_rules done");

		// level bit drives the pin when the test bit is clear
		wr_ctrl(8'h80);
		check("pin_released", {7'h0, pin_oe}, 8'h00);
		check("pin_wire_high", {7'h0, pin_wire}, 8'h01);
		wr_ctrl(8'h00);
		check("pin_pulled", {7'h0, pin_oe}, 8'h01);
		$display("test level_pin done");

		// 512 Hz test wave, unchanged by either calibration sign
		foreach (pat[i]) begin
			if (i < 3) begin
				wr_ctrl(i == 0 ? 8'h40 : (i == 1 ? 8'h5F : 8'h7F));
				count_toggles(2560, tg);
				check("test_toggles", {7'h0, tg >= 19 && tg <= 21}, 8'h01);
			end
		end
		$display("test freq_test done");

		// halt stops the divider, clearing resumes it
		host.set_ptr(ADDR_SECONDS);
		host.wr(8'h80);
		count_toggles(600, tg);
		check("halted_toggles", tg[7:0], 8'h00);
		host.set_ptr(ADDR_SECONDS);
		host.rd(1'b0, d);
		host.rd_end();
		check("halt_bit", d, 8'h80);
		host.set_ptr(ADDR_SECONDS);
		host.wr(8'h00);
		count_toggles(2560, tg);
		check("resumed_toggles", {7'h0, tg >= 19 && tg <= 21}, 8'h01);
		$display("test halt_restart done");

		// first tick rolls the century; copy held while a time read stays open
		osc_half = 100; // two-cycle crystal period halves the wait for the tick
		host.set_ptr(ADDR_SECONDS);
		for (int i = 0; i < 7; i++) host.wr(roll_set[i]);
		host.set_ptr(ADDR_SECONDS);
		host.rd(1'b0, d);
		wait (DUT.sec_tick === 1'b1);
		repeat (3) @(negedge clk);
		host.rd(1'b0, d);
		check("copy_held", d, 8'h59);
		repeat (25) @(negedge clk);
		host.rd(1'b0, d);
		check("copy_forced", d, 8'h00);
		for (int i = 0; i < 7; i++) begin
			host.rd(1'b1, d);
			check("rollover", d, roll_exp[i]);
		end
		host.rd_end();
		$display("test rollover done");

		final_report();
	end
endmodule : tb
`default_nettype wire
